// *** verilog/gcs_pkg.sv ***
// shared constants, types and carriers of the gauge coil scan sequencer
package gcs_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NCOIL  = 12;  // coils serviced per scan cycle
  localparam int unsigned NGAUGE = 6;   // two coils per gauge
  localparam int unsigned NMAJOR = 2;   // gauges 0..1 are full-bridge on both coils

  // ----------------------------------------------------------------
  // register offsets (cpu byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MAG_BASE = 8'h22;  // coil_magnitude_reg, coil 1 .. 12
  localparam logic [7:0] ADDR_DIR_BASE = 8'h2E;  // coil_direction_reg, gauge order
  localparam logic [7:0] ADDR_SCAN     = 8'h34;  // scan_status_control
  localparam logic [7:0] ADDR_GEN      = 8'h35;  // gauge_enable_reg

  // ----------------------------------------------------------------
  // scan_status_control field positions
  // ----------------------------------------------------------------
  localparam int unsigned SC_CLK_LO = 0;  // scan_clk_sel_lo
  localparam int unsigned SC_CLK_HI = 1;  // scan_clk_sel_hi
  localparam int unsigned SC_AUTO   = 2;  // auto_mode_select
  localparam int unsigned SC_START  = 3;  // scan_start_bit
  localparam int unsigned SC_CLR    = 5;  // sync_flag_clear, reads zero
  localparam int unsigned SC_FLAG   = 6;  // sync_flag, read only
  localparam int unsigned SC_IE     = 7;  // sync_irq_enable

  // direction bits: major gauge bit0 coil1, bit1 coil2; minor gauge bit0 coil2
  localparam int unsigned DIR_BIT0 = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MAG  = 8'h00;
  localparam logic [1:0] RST_DIR  = 2'h0;
  localparam logic [5:0] RST_GEN  = 6'h00;
  localparam logic [1:0] RST_SEL  = 2'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [12:0] DIV_SEL0 = 13'h0200;  // 512 bus clocks per coil
  localparam logic [12:0] DIV_SEL1 = 13'h0400;  // 1024
  localparam logic [12:0] DIV_SEL2 = 13'h0800;  // 2048
  localparam logic [12:0] DIV_SEL3 = 13'h1000;  // 4096
  localparam int unsigned CLK_NS      = 40;     // i_mclk period
  localparam int unsigned DAC_WAIT_NS = 400;    // converter output to mux
  localparam int unsigned DAC_WAIT_CYC = (DAC_WAIT_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_OPEN   = 3'b001,
    ST_LOAD   = 3'b011,
    ST_CONV   = 3'b010,
    ST_SETTLE = 3'b110
  } gcs_state_e;

  typedef struct packed {
    logic       wr;     // one-cycle write strobe
    logic       rd;     // one-cycle read strobe
    logic [7:0] addr;
    logic [7:0] wdata;
  } gcs_bus_s;

  typedef struct packed {
    logic [11:0] hold_sel;  // one-hot closed sample-and-hold switch
    logic [7:0]  dac;       // converter input
    logic        dir_rev;   // 1: current from minus pin to plus pin
    logic [5:0]  drv_on;    // per-gauge driver enable
  } gcs_drive_s;

endpackage

// *** verilog/gcs_sequencer.sv ***
// gauge coil scan sequencer: registers, double buffers and coil stepping
// Contract
// - twelve coils, one update period each
// - fixed coil order one through twelve
// - automatic mode restarts scan without trigger
// - automatic transfer at each gauge start
// - automatic transfer only after both magnitudes written
// - manual start launches exactly one scan
// - manual transfer at gauge start regardless
// - disabled gauge spends time, driver off
// - only slave copies drive outputs
// - open, advance, transfer, load, close, settle
// - minor direction one means minus to plus
// - interrupt when enable and flag set
// - flag sets at coil eleven start
// - clear needs prior read; reset clears
// - flag clear bit always reads zero
// - clock select divides by 512..4096
// - mode bit one automatic, zero manual
// - start transfers all, self-clears, ignored extras
// - magnitude reads return slave; reset clears
`timescale 1ns/1ps

module gcs_sequencer (
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  input  wire gcs_pkg::gcs_bus_s  i_bus,
  output logic [7:0]              o_rd_data,
  output logic                    o_irq,
  output gcs_pkg::gcs_drive_s     o_drive
);
  import gcs_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // last count of a coil period for a clock select setting
  function automatic logic [11:0] div_last(input logic [1:0] sel);
    logic [12:0] d;
    d = DIV_SEL0;
    case (sel)
      2'b00:   d = DIV_SEL0;
      2'b01:   d = DIV_SEL1;
      2'b10:   d = DIV_SEL2;
      default: d = DIV_SEL3;
    endcase
    return 12'(d - 13'd1);
  endfunction

  // direction of a coil from its gauge's slave direction bits
  function automatic logic coil_dir(input logic [3:0] c, input logic [1:0] d);
    if (int'(c[3:1]) < NMAJOR) begin
      return d[c[0]];
    end
    return c[0] ? d[DIR_BIT0] : 1'b0;  // coil 1 of a minor gauge is half-bridge
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  mag_m_ff [NCOIL];     // master, last value written
  logic [7:0]  mag_s_ff [NCOIL];     // slave, feeds the converter
  logic [1:0]  dir_m_ff [NGAUGE];
  logic [1:0]  dir_s_ff [NGAUGE];
  logic [1:0]  wseen_ff [NGAUGE];    // magnitude writes since last transfer
  logic [7:0]  nxt_mag_m [NCOIL];
  logic [7:0]  nxt_mag_s [NCOIL];
  logic [1:0]  nxt_dir_m [NGAUGE];
  logic [1:0]  nxt_dir_s [NGAUGE];
  logic [1:0]  nxt_wseen [NGAUGE];
  logic [5:0]  gen_ff,   nxt_gen;    // gauge enables
  logic [1:0]  sel_ff,   nxt_sel;    // clock select
  logic        auto_ff,  nxt_auto;
  logic        start_ff, nxt_start;
  logic        flag_ff,  nxt_flag;
  logic        seen_ff,  nxt_seen;   // flag observed set by a read
  logic        ie_ff,    nxt_ie;
  logic        irq_ff,   nxt_irq;
  logic [7:0]  rd_ff,    nxt_rd;

  gcs_state_e  st_ff,    nxt_st;
  logic [3:0]  ptr_ff,   nxt_ptr;    // coil index 0..11
  logic [11:0] cnt_ff,   nxt_cnt;    // cycles into the coil period
  gcs_drive_s  drv_ff,   nxt_drv;

  // decoded bus events
  logic        mag_hit, dir_hit, scan_wr, start_wr, coil11, gauge_start;
  logic [3:0]  mag_idx;
  logic [7:0]  mag_off;   // whole byte offset from the first magnitude
  logic [7:0]  dir_off;
  logic [5:0]  xfer_v;
  logic [2:0]  cur_g;
  logic        per_end;
  logic [7:0]  dac_src;

  // range test on the full offset: a four-bit cut would alias 0x32..0x35 onto coils
  assign mag_off     = i_bus.addr - ADDR_MAG_BASE;
  assign mag_idx     = mag_off[3:0];
  assign mag_hit     = (i_bus.addr >= ADDR_MAG_BASE) && (mag_off < 8'(NCOIL));
  assign dir_off     = i_bus.addr - ADDR_DIR_BASE;
  assign dir_hit     = (i_bus.addr >= ADDR_DIR_BASE) && (dir_off < 8'(NGAUGE));
  assign scan_wr     = i_bus.wr && (i_bus.addr == ADDR_SCAN);
  // extra start writes while set, or any in automatic mode, are dropped
  assign start_wr    = scan_wr && i_bus.wdata[SC_START] && !auto_ff && !start_ff;
  assign gauge_start = (st_ff == ST_OPEN) && !ptr_ff[0];
  assign coil11      = (st_ff == ST_OPEN) && (ptr_ff == 4'd10);
  assign cur_g       = ptr_ff[3:1];
  assign per_end     = (cnt_ff >= div_last(sel_ff));
  assign dac_src     = mag_s_ff[ptr_ff];

  // ----------------------------------------------------------------
  // register file: next values
  // ----------------------------------------------------------------
  // transfer first, cpu write after, so a write landing in the transfer
  // cycle keeps its tracking bit and waits for the next gauge start
  always_comb begin
    nxt_mag_m = mag_m_ff;
    nxt_mag_s = mag_s_ff;
    nxt_dir_m = dir_m_ff;
    nxt_dir_s = dir_s_ff;
    nxt_wseen = wseen_ff;
    nxt_gen   = gen_ff;
    nxt_sel   = sel_ff;
    nxt_auto  = auto_ff;
    nxt_start = start_ff;
    nxt_flag  = flag_ff;
    nxt_seen  = seen_ff;
    nxt_ie    = ie_ff;
    nxt_rd    = rd_ff;
    xfer_v    = '0;
    // gauge start transfer, qualified only in automatic mode
    if (gauge_start) begin
      if (!auto_ff || (wseen_ff[cur_g] == 2'b11)) begin
        xfer_v[cur_g] = 1'b1;
      end
    end
    if (start_wr) begin
      xfer_v = '1;
    end
    for (int g = 0; g < NGAUGE; g++) begin
      if (xfer_v[g]) begin
        nxt_mag_s[2*g]   = mag_m_ff[2*g];
        nxt_mag_s[2*g+1] = mag_m_ff[2*g+1];
        nxt_dir_s[g]     = dir_m_ff[g];
        nxt_wseen[g]     = 2'b00;
      end
    end
    // cpu writes
    if (i_bus.wr) begin
      if (mag_hit) begin
        nxt_mag_m[mag_idx] = i_bus.wdata;
        nxt_wseen[mag_idx[3:1]][mag_idx[0]] = 1'b1;
      end else if (dir_hit) begin
        // minor gauges carry one direction bit only
        nxt_dir_m[dir_off[2:0]] = (int'(dir_off) < NMAJOR) ?
                                  i_bus.wdata[1:0] : {1'b0, i_bus.wdata[DIR_BIT0]};
      end else if (i_bus.addr == ADDR_GEN) begin
        nxt_gen = i_bus.wdata[5:0];
      end
    end
    if (scan_wr) begin
      nxt_sel  = {i_bus.wdata[SC_CLK_HI], i_bus.wdata[SC_CLK_LO]};
      nxt_auto = i_bus.wdata[SC_AUTO];
      nxt_ie   = i_bus.wdata[SC_IE];
      // clear only after the flag was seen set by a read
      if (i_bus.wdata[SC_CLR] && seen_ff) begin
        nxt_flag = 1'b0;
        nxt_seen = 1'b0;
      end
    end
    if (start_wr) begin
      nxt_start = 1'b1;
    end
    // coil 11 start: flag sets (wins over a clear), start self-clears
    if (coil11) begin
      nxt_flag  = 1'b1;
      nxt_start = 1'b0;
    end
    // read port, with the read side effect on the flag
    if (i_bus.rd) begin
      nxt_rd = 8'h00;
      if (mag_hit) begin
        nxt_rd = mag_s_ff[mag_idx];
      end else if (dir_hit) begin
        nxt_rd = {6'h00, dir_s_ff[dir_off[2:0]]};
      end else if (i_bus.addr == ADDR_GEN) begin
        nxt_rd = {2'b00, gen_ff};
      end else if (i_bus.addr == ADDR_SCAN) begin
        nxt_rd = '0;  // clear bit and bit 4 read zero
        nxt_rd[SC_IE]     = ie_ff;
        nxt_rd[SC_FLAG]   = flag_ff;
        nxt_rd[SC_START]  = start_ff;
        nxt_rd[SC_AUTO]   = auto_ff;
        nxt_rd[SC_CLK_HI] = sel_ff[1];
        nxt_rd[SC_CLK_LO] = sel_ff[0];
        if (flag_ff) begin
          nxt_seen = 1'b1;
        end
      end
    end
    nxt_irq = nxt_ie && nxt_flag;
  end

  // ----------------------------------------------------------------
  // register file: flops
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      for (int c = 0; c < NCOIL; c++) begin
        mag_m_ff[c] <= RST_MAG;
        mag_s_ff[c] <= RST_MAG;
      end
      for (int g = 0; g < NGAUGE; g++) begin
        dir_m_ff[g] <= RST_DIR;
        dir_s_ff[g] <= RST_DIR;
        wseen_ff[g] <= 2'b00;
      end
      gen_ff   <= RST_GEN;
      sel_ff   <= RST_SEL;
      auto_ff  <= 1'b0;
      start_ff <= 1'b0;
      flag_ff  <= 1'b0;
      seen_ff  <= 1'b0;
      ie_ff    <= 1'b0;
      irq_ff   <= 1'b0;
      rd_ff    <= 8'h00;
    end else begin
      mag_m_ff <= nxt_mag_m;
      mag_s_ff <= nxt_mag_s;
      dir_m_ff <= nxt_dir_m;
      dir_s_ff <= nxt_dir_s;
      wseen_ff <= nxt_wseen;
      gen_ff   <= nxt_gen;
      sel_ff   <= nxt_sel;
      auto_ff  <= nxt_auto;
      start_ff <= nxt_start;
      flag_ff  <= nxt_flag;
      seen_ff  <= nxt_seen;
      ie_ff    <= nxt_ie;
      irq_ff   <= nxt_irq;
      rd_ff    <= nxt_rd;
    end
  end

  // ----------------------------------------------------------------
  // coil stepper: next values
  // ----------------------------------------------------------------
  // the period counter doubles as the divider, so with a steady clock select a coil lasts
  // exactly one divided period whatever the phase split inside it
  always_comb begin
    nxt_st  = st_ff;
    nxt_ptr = ptr_ff;
    nxt_cnt = cnt_ff + 12'd1;
    nxt_drv = drv_ff;
    nxt_drv.drv_on = gen_ff;
    case (st_ff)
      ST_IDLE: begin
        nxt_cnt = 12'd0;
        nxt_ptr = 4'd0;
        nxt_drv.hold_sel = '0;
        if (auto_ff || start_ff) begin
          nxt_st = ST_OPEN;
        end
      end
      ST_OPEN: begin
        // switches already open; at a gauge start the transfer happens this cycle
        nxt_st = ST_LOAD;
      end
      ST_LOAD: begin
        nxt_drv.dac = dac_src;  // slave only
        nxt_st = ST_CONV;
      end
      ST_CONV: begin
        if (cnt_ff >= 12'(DAC_WAIT_CYC + 1)) begin
          // disabled gauge keeps its switch open and driver off
          if (gen_ff[cur_g]) begin
            nxt_drv.hold_sel = 12'(1) << ptr_ff;
          end
          nxt_drv.dir_rev = coil_dir(ptr_ff, dir_s_ff[cur_g]);
          nxt_st = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (per_end) begin
          nxt_cnt = 12'd0;
          nxt_drv.hold_sel = '0;  // open all before stepping
          if (ptr_ff != 4'(NCOIL - 1)) begin
            nxt_ptr = ptr_ff + 4'd1;
            nxt_st  = ST_OPEN;
          end else if (auto_ff || start_ff) begin
            nxt_ptr = 4'd0;
            nxt_st  = ST_OPEN;
          end else begin
            nxt_st  = ST_IDLE;  // one scan per start
          end
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // coil stepper: flops
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_ff  <= ST_IDLE;
      ptr_ff <= 4'd0;
      cnt_ff <= 12'd0;
      drv_ff <= '0;
    end else begin
      st_ff  <= nxt_st;
      ptr_ff <= nxt_ptr;
      cnt_ff <= nxt_cnt;
      drv_ff <= nxt_drv;
    end
  end

  assign o_rd_data = rd_ff;
  assign o_irq     = irq_ff;
  assign o_drive   = drv_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_ptr_range: assert property (ptr_ff < 4'd12)
    else $error("coil pointer beyond twelve");
  a_coil_order: assert property ((st_ff == ST_SETTLE && per_end && ptr_ff != 4'd11)
    |=> st_ff == ST_OPEN && ptr_ff == $past(ptr_ff) + 4'd1)
    else $error("coil order broken");
  a_auto_wrap: assert property ((auto_ff && st_ff == ST_SETTLE && per_end
    && ptr_ff == 4'd11) |=> st_ff == ST_OPEN && ptr_ff == 4'd0)
    else $error("automatic scan did not restart");
  a_open_first: assert property ((st_ff == ST_OPEN) |-> drv_ff.hold_sel == 12'h000
    ##1 st_ff == ST_LOAD ##1 st_ff == ST_CONV && drv_ff.dac == $past(dac_src))
    else $error("coil step sequence wrong");
  a_flag_set: assert property (coil11 |=> flag_ff && !start_ff)
    else $error("flag or start wrong at coil eleven");
  a_irq_gate: assert property (irq_ff == (ie_ff && flag_ff))
    else $error("interrupt does not follow enable and flag");
  a_clr_zero: assert property ((i_bus.rd && i_bus.addr == ADDR_SCAN)
    |=> !o_rd_data[SC_CLR])
    else $error("flag clear bit read as one");
  a_dis_off: assert property ((st_ff == ST_CONV && !gen_ff[cur_g]) |=>
    drv_ff.hold_sel == 12'h000)
    else $error("disabled gauge switch closed");
  a_period_len: assert property ((st_ff == ST_SETTLE && per_end
    && $stable(sel_ff)) |-> cnt_ff == div_last(sel_ff))
    else $error("coil period length wrong");

endmodule

// *** verification/gcs_coil_model.sv ***
// coil driver model: sample-and-hold capture behind the shared converter
`timescale 1ns/1ps

// ----------------------------------------------------------------
// coil driver model
// ----------------------------------------------------------------
module gcs_coil_model (
  input  wire logic                 i_mclk,
  input  wire gcs_pkg::gcs_drive_s  i_drive,
  output logic [11:0][7:0]          o_mag,
  output logic [11:0]               o_dir,
  output int                        o_closures
);
  import gcs_pkg::*;

  logic [11:0] prev_sel;  // last switch pattern, to spot closures

  // held levels start at zero, like discharged hold capacitors
  initial begin
    o_mag = '0;
    o_dir = '0;
    o_closures = 0;
    prev_sel = '0;
  end

  // a closed switch follows converter and polarity, an open one holds
  always @(posedge i_mclk) begin
    for (int k = 0; k < 12; k++) begin
      if (i_drive.hold_sel[k] === 1'b1) begin
        o_mag[k] <= i_drive.dac;
        o_dir[k] <= i_drive.dir_rev;
      end
    end
    // counted once per closure, not per cycle held
    if ((i_drive.hold_sel != 12'h000) && (prev_sel == 12'h000)) begin
      o_closures <= o_closures + 1;
    end
    prev_sel <= i_drive.hold_sel;
  end
endmodule

// *** verification/gauge_coil_scan_sequencer_tb.sv ***
// self-checking bench of the gauge coil scan sequencer
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("mismatch t=%0t got %h exp %h", $time, (got), (exp)); end end

module gauge_coil_scan_sequencer_tb;
  import gcs_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic             i_mclk = 1'b0;
  logic             i_rst_n = 1'b0;  // active low
  gcs_bus_s         bus = '0;        // driven at falling edges only
  logic [7:0]       rd_data;
  logic             irq;
  gcs_drive_s       drive;
  logic [11:0][7:0] mag;             // held coil levels in the model
  logic [11:0]      dir;
  int               closures;
  int               cyc = 0;         // rising edges since start
  int               err_total = 0;
  int               num_checks = 0;
  int               t0, t1, s0, d0;
  logic [5:0][7:0]  dir_vals = {8'h01, 8'h00, 8'h01, 8'h00, 8'h02, 8'h01};

  always #20 i_mclk = ~i_mclk;
  always @(posedge i_mclk) cyc <= cyc + 1;

  gcs_sequencer i_gcs_sequencer (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_bus     (bus),
    .o_rd_data (rd_data),
    .o_irq     (irq),
    .o_drive   (drive)
  );

  gcs_coil_model i_gcs_coil_model (
    .i_mclk     (i_mclk),
    .i_drive    (drive),
    .o_mag      (mag),
    .o_dir      (dir),
    .o_closures (closures)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if ((err_total == 0) && (num_checks > 0)) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic end_test(input string n);
    $display("test %s ended, mismatches so far %0d", n, err_total);
  endtask

  // one-cycle strobe; the write lands at the edge in between
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    bus.wr = 1'b1;
    bus.addr = a;
    bus.wdata = d;
    @(negedge i_mclk);
    bus.wr = 1'b0;
  endtask

  // data is registered, so sample a full cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_mclk);
    bus.rd = 1'b1;
    bus.addr = a;
    @(negedge i_mclk);
    bus.rd = 1'b0;
    @(negedge i_mclk);
    `CHK(rd_data, e)
  endtask

  // next switch closure, bounded well above the slowest coil period
  task automatic wait_hold(output int t);
    int c;
    c = closures;
    for (int n = 0; n < 20000; n++) begin
      @(negedge i_mclk);
      if (closures != c) begin
        t = cyc;
        return;
      end
    end
    err_total++;
    $display("timeout waiting for a coil closure");
    complete_run();
  endtask

  // closure of one given coil within one scan and a bit
  task automatic wait_coil(input int k, output int t);
    for (int n = 0; n < 13; n++) begin
      wait_hold(t);
      if (drive.hold_sel[k] === 1'b1) return;
    end
    err_total++;
    $display("coil %0d never closed", k);
    complete_run();
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(negedge i_mclk);
    i_rst_n = 1'b1;
    for (int a = 0; a < 20; a++) rchk(8'(8'h22 + a), 8'h00);
    rchk(8'h10, 8'h00);
    end_test("reset values");
    // directions first, then enables and magnitudes
    for (int g = 0; g < 6; g++) wr(8'(8'h2E + g), dir_vals[g]);
    wr(8'h35, 8'h3F);
    for (int k = 0; k < 12; k++) wr(8'(8'h22 + k), 8'(8'h21 + k));
    rchk(8'h22, 8'h00);
    wr(8'h34, 8'h88);
    s0 = cyc;
    for (int k = 0; k < 12; k++) begin
      wait_coil(k, t1);
      if (k == 0) begin
        d0 = t1 - s0;
        rchk(8'h22, 8'h21);
        rchk(8'h2E, 8'h01);
        rchk(8'h34, 8'h88);
      end else `CHK(t1 - t0, 512)
      t0 = t1;
      if (k == 4) wr(8'h34, 8'h88);
      if (k == 9) `CHK(irq, 1'b0)
      if (k == 10) `CHK(irq, 1'b1)
    end
    for (int k = 0; k < 12; k++) `CHK(mag[k], 8'(8'h21 + k))
    `CHK(dir, 12'h889)
    // a clear without a read that saw the flag must not work
    wr(8'h34, 8'hA0);
    rchk(8'h34, 8'hC0);
    wr(8'h34, 8'hA0);
    rchk(8'h34, 8'h80);
    `CHK(irq, 1'b0)
    repeat (1200) @(negedge i_mclk);
    `CHK(closures, 12)
    end_test("manual scan");
    // gauge 0 off: timing must not move, its switches stay open
    wr(8'h35, 8'h3E);
    wr(8'h24, 8'h5A);
    wr(8'h34, 8'h08);
    s0 = cyc;
    wait_coil(2, t1);
    `CHK(t1 - s0, d0 + 1024)
    `CHK(drive.drv_on, 6'h3E)
    wr(8'h28, 8'h77);
    wait_coil(11, t1);
    `CHK(mag[6], 8'h77)
    `CHK(mag[2], 8'h5A)
    `CHK(mag[0], 8'h21)
    `CHK(closures, 22)
    end_test("disabled gauge");
    // automatic mode: only fully written gauges move
    wr(8'h34, 8'h04);
    wait_coil(10, t1);
    wr(8'h24, 8'hA1);
    wr(8'h26, 8'hB1);
    wr(8'h27, 8'hB2);
    wait_coil(5, t1);
    `CHK(mag[2], 8'h5A)
    `CHK(mag[4], 8'hB1)
    `CHK(mag[5], 8'hB2)
    wr(8'h25, 8'hA2);
    wait_coil(3, t1);
    `CHK(mag[2], 8'hA1)
    `CHK(mag[3], 8'hA2)
    wr(8'h24, 8'hC3);
    wait_coil(11, t1);
    wait_coil(3, t1);
    `CHK(mag[2], 8'hA1)
    end_test("auto scan");
    // first closure after a change may be odd, so time the next pair
    wr(8'h35, 8'h3F);
    for (int s = 1; s < 4; s++) begin
      wr(8'h34, 8'(8'h04 + s));
      wait_hold(t0);
      wait_hold(t0);
      wait_hold(t1);
      `CHK(t1 - t0, 512 << s)
    end
    end_test("clock select");
    // reset in mid-run returns everything to idle
    @(negedge i_mclk);
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_mclk);
    i_rst_n = 1'b1;
    `CHK(drive, '0)
    `CHK(irq, 1'b0)
    rchk(8'h34, 8'h00);
    rchk(8'h24, 8'h00);
    t0 = closures;
    repeat (600) @(negedge i_mclk);
    `CHK(closures, t0)
    end_test("mid-run reset");
    complete_run();
  end
endmodule
